// [fpia_pkg.sv]
// Purpose: Shared constants for the flag polarity and interrupt aggregator
// Assumes: 16-bit register words, 10-bit register index
// Notes:   Offsets are register indices on the internal register port
package fpia_pkg;
  localparam int          REG_AW          = 10;
  localparam int          REG_DW          = 16;
  localparam int          NUM_FLAGS       = 13;
  localparam int          NUM_SRC         = 13;
  localparam int          NUM_START       = 6;
  localparam int          START_LSB       = 3;
  localparam int          FIXED_PIN_FLAGS = 3;
  localparam logic [9:0]  ADDR_FLAG_POL   = 10'h1c2;
  localparam logic [9:0]  ADDR_CAUSE      = 10'h1d4;
  localparam logic [15:0] FLAG_POL_RST    = 16'h0000;
  localparam logic [15:0] CAUSE_RST       = 16'h0000;
  // Cause latch field positions
  localparam int          CS_HALT_LSB     = 0;
  localparam int          CS_SOFT_LSB     = 4;
  localparam int          CS_DRV          = 8;
  localparam int          CS_SERIAL       = 9;
  localparam int          CS_CLK_MISS     = 10;
  localparam int          CS_CODE_LSB     = 11;
endpackage : fpia_pkg

// [fpia_polarity.sv]
// Purpose: Per-flag polarity, pin routing and trigger input levels
// Assumes: Source and direction selections arrive from their own registers
// Notes:   All outputs registered; three lowest flags are always pins
`timescale 1ns/1ps
`default_nettype none
module fpia_polarity #(
  parameter int NF = fpia_pkg::NUM_FLAGS,
  parameter int NS = fpia_pkg::NUM_START
) (
  input  wire logic          i_core_clk,  // System clock
  input  wire logic          i_nrst,      // Async reset, active low
  input  wire logic [NF-1:0] i_pol,       // Polarity bits
  input  wire logic [NF-1:0] i_src,       // 1 routes flag to its pin
  input  wire logic [NF-1:0] i_dir,       // 1 pin drives the flag bus
  input  wire logic [NF-1:0] i_int_flags, // Internal flags from channels
  input  wire logic [NF-1:0] i_pin_in,    // Pin input levels
  output logic      [NF-1:0] o_flag_bus,  // Flag bus to channels
  output logic      [NF-1:0] o_pin_out,   // Pin output levels
  output logic      [NF-1:0] o_pin_oe,    // Pin output enables
  output logic      [NS-1:0] o_trig_act   // Trigger inputs, active high
);
  logic [NF-1:0] src_eff;
  logic [NF-1:0] bus_d;
  logic [NF-1:0] pout_d;
  logic [NF-1:0] oe_d;
  logic [NS-1:0] trig_d;

  // Lowest flags have no alternate function
  assign src_eff = i_src | NF'({fpia_pkg::FIXED_PIN_FLAGS{1'b1}});

  always_comb begin
    for (int i = 0; i < NF; i++) begin
      if (src_eff[i] && i_dir[i]) begin
        bus_d[i]  = i_pin_in[i] ^ i_pol[i];
        pout_d[i] = 1'b0;
        oe_d[i]   = 1'b0;
      end else if (src_eff[i]) begin
        bus_d[i]  = i_int_flags[i];
        pout_d[i] = i_int_flags[i] ^ i_pol[i];
        oe_d[i]   = 1'b1;
      end else begin
        bus_d[i]  = i_int_flags[i];
        pout_d[i] = 1'b0;
        oe_d[i]   = 1'b0;
      end
    end
    for (int k = 0; k < NS; k++) begin
      trig_d[k] = !src_eff[k+fpia_pkg::START_LSB] &&
                  (i_pin_in[k+fpia_pkg::START_LSB] ^
                   i_pol[k+fpia_pkg::START_LSB]);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_flag_bus <= '0;
      o_pin_out  <= '0;
      o_pin_oe   <= '0;
      o_trig_act <= '0;
    end else begin
      o_flag_bus <= bus_d;
      o_pin_out  <= pout_d;
      o_pin_oe   <= oe_d;
      o_trig_act <= trig_d;
    end
  end
endmodule : fpia_polarity
`default_nettype wire

// [fpia_top.sv]
// Purpose: Flag polarity control and host interrupt aggregation
// Assumes: Sources are already gated by their own enable registers
// Notes:   Registers reached over the internal serial-port register port
`timescale 1ns/1ps
`default_nettype none
module fpia_top #(
  parameter int NF = fpia_pkg::NUM_FLAGS,
  parameter int NS = fpia_pkg::NUM_START
) (
  input  wire logic                      i_core_clk,     // System clock
  input  wire logic                      i_nrst,         // Async reset
  input  wire logic [fpia_pkg::REG_AW-1:0] i_reg_addr,   // Register index
  input  wire logic                      i_reg_wr,       // Write strobe
  input  wire logic                      i_reg_rd,       // Read strobe
  input  wire logic [fpia_pkg::REG_DW-1:0] i_reg_wdata,  // Write data
  output logic      [fpia_pkg::REG_DW-1:0] o_reg_rdata,  // Read data
  input  wire logic [3:0]                i_core_short_halt,   // Halts
  input  wire logic [3:0]                i_core_soft_request, // uc reqs
  input  wire logic                      i_drv_disabled, // Drivers off
  input  wire logic                      i_serial_err,   // Serial error
  input  wire logic                      i_clk_missing,  // Clock lost
  input  wire logic                      i_code_check_fail_chan_one, // Sig
  input  wire logic                      i_code_check_fail_chan_two, // Sig
  input  wire logic [NF-1:0]             i_flag_src,     // Source select
  input  wire logic [NF-1:0]             i_flag_dir,     // Direction
  input  wire logic [NF-1:0]             i_int_flags,    // Internal flags
  input  wire logic [NF-1:0]             i_pin_in,       // Pin levels
  output logic      [NF-1:0]             o_flag_bus,     // Flag bus
  output logic      [NF-1:0]             o_pin_out,      // Pin outputs
  output logic      [NF-1:0]             o_pin_oe,       // Pin enables
  output logic      [NS-1:0]             o_trig_act,     // Triggers
  output logic                           o_host_request_pin_n // Host irq
);
  logic [NF-1:0]                 flag_pol_q;
  logic [fpia_pkg::REG_DW-1:0]   cause_q;
  logic [fpia_pkg::REG_DW-1:0]   cause_d;
  logic [fpia_pkg::NUM_SRC-1:0]  src_vec;
  logic                          any_req;
  logic                          req_q;

  function automatic logic [fpia_pkg::REG_DW-1:0] pad16(
    input logic [fpia_pkg::NUM_SRC-1:0] v
  );
    pad16 = {3'h0, v};
  endfunction : pad16

  // Source vector in cause latch bit order
  assign src_vec = {i_code_check_fail_chan_two,
                    i_code_check_fail_chan_one,
                    i_clk_missing,
                    i_serial_err,
                    i_drv_disabled,
                    i_core_soft_request,
                    i_core_short_halt};

  assign any_req = |src_vec;

  // Polarity register, write only at its own index
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      flag_pol_q <= fpia_pkg::FLAG_POL_RST[NF-1:0];
    end else if (i_reg_wr && i_reg_addr == fpia_pkg::ADDR_FLAG_POL) begin
      flag_pol_q <= i_reg_wdata[NF-1:0];
    end
  end

  // Request state
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      req_q <= 1'b0;
    end else begin
      req_q <= any_req;
    end
  end

  always_comb begin
    if (!any_req) begin
      cause_d = fpia_pkg::CAUSE_RST;
    end else if (!req_q) begin
      cause_d = pad16(src_vec);
    end else begin
      cause_d = cause_q;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cause_q <= fpia_pkg::CAUSE_RST;
    end else begin
      cause_q <= cause_d;
    end
  end

  assign o_host_request_pin_n = !req_q;

  // Read data; writes to the cause latch are ignored
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_reg_rdata <= '0;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        fpia_pkg::ADDR_FLAG_POL: o_reg_rdata <= {3'h0, flag_pol_q};
        fpia_pkg::ADDR_CAUSE:    o_reg_rdata <= cause_q;
        default:                 o_reg_rdata <= '0;
      endcase
    end
  end

  fpia_polarity #(
    .NF (NF),
    .NS (NS)
  ) u_pol (
    .i_core_clk  (i_core_clk),
    .i_nrst      (i_nrst),
    .i_pol       (flag_pol_q),
    .i_src       (i_flag_src),
    .i_dir       (i_flag_dir),
    .i_int_flags (i_int_flags),
    .i_pin_in    (i_pin_in),
    .o_flag_bus  (o_flag_bus),
    .o_pin_out   (o_pin_out),
    .o_pin_oe    (o_pin_oe),
    .o_trig_act  (o_trig_act)
  );

  // Checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_req_rise;
    !any_req ##1 any_req;
  endsequence

  sequence s_req_held;
    any_req [*2];
  endsequence

  a_pin_follows_req: assert property (
    any_req |=> !o_host_request_pin_n)
    else $error("request pin not low after source request");

  a_pin_release: assert property (
    !any_req |=> o_host_request_pin_n && cause_q == 16'h0000)
    else $error("pin or cause latch not released");

  a_capture_edge: assert property (
    s_req_rise |=> cause_q == pad16($past(src_vec)))
    else $error("cause latch missed sources on assertion");

  a_capture_cycle: assert property (
    $fell(o_host_request_pin_n) |->
      cause_q != 16'h0000 && cause_q == pad16($past(src_vec)))
    else $error("cause not captured with pin assertion");

  a_cause_hold: assert property (
    s_req_held |=> $stable(cause_q))
    else $error("cause latch changed while pin asserted");

  a_reserved_zero: assert property (
    cause_q[15:13] == 3'h0 && (o_reg_rdata[15:13] == 3'h0))
    else $error("reserved bits not zero");

  a_cause_read: assert property (
    i_reg_rd && i_reg_addr == fpia_pkg::ADDR_CAUSE
      |=> o_reg_rdata == $past(cause_q))
    else $error("cause read returned wrong value");

  a_pol_write: assert property (
    i_reg_wr && i_reg_addr == fpia_pkg::ADDR_FLAG_POL
      |=> flag_pol_q == $past(i_reg_wdata[NF-1:0]))
    else $error("polarity write not stored");

  a_out_invert: assert property (
    i_flag_src[5] && !i_flag_dir[5]
      |=> o_pin_out[5] == ($past(i_int_flags[5]) ^ $past(flag_pol_q[5]))
          && o_pin_oe[5])
    else $error("output flag polarity wrong");

  a_in_invert: assert property (
    i_flag_dir[0]
      |=> o_flag_bus[0] == ($past(i_pin_in[0]) ^ $past(flag_pol_q[0]))
          && !o_pin_oe[0])
    else $error("input flag polarity wrong");

  a_unrouted_pass: assert property (
    !i_flag_src[10] |=> o_flag_bus[10] == $past(i_int_flags[10])
                        && !o_pin_oe[10])
    else $error("polarity applied to unrouted flag");

  a_trig_level: assert property (
    !i_flag_src[3]
      |=> o_trig_act[0] == ($past(i_pin_in[3]) ^ $past(flag_pol_q[3])))
    else $error("trigger level wrong");

  a_halt_bits: assert property (
    s_req_rise |=> cause_q[3:0] == $past(i_core_short_halt))
    else $error("halt bits not captured");

  a_soft_bits: assert property (
    s_req_rise |=> cause_q[7:4] == $past(i_core_soft_request))
    else $error("microcore request bits not captured");

  a_drv_bit: assert property (
    s_req_rise |=> cause_q[fpia_pkg::CS_DRV] == $past(i_drv_disabled))
    else $error("driver disable bit not captured");

  a_serial_bit: assert property (
    s_req_rise |=> cause_q[fpia_pkg::CS_SERIAL] == $past(i_serial_err))
    else $error("serial error bit not captured");

  a_clk_bit: assert property (
    s_req_rise |=> cause_q[fpia_pkg::CS_CLK_MISS] == $past(i_clk_missing))
    else $error("clock missing bit not captured");

  a_code_bits: assert property (
    s_req_rise |=> cause_q[12:11] == {$past(i_code_check_fail_chan_two),
                                      $past(i_code_check_fail_chan_one)})
    else $error("code check bits not captured");

  a_cause_idle: assert property (
    o_host_request_pin_n |-> cause_q == 16'h0000)
    else $error("cause latch set while pin released");

  a_pin_low_cause: assert property (
    !o_host_request_pin_n |-> cause_q != 16'h0000)
    else $error("pin asserted with empty cause latch");

  a_pol_rdback: assert property (
    i_reg_rd && i_reg_addr == fpia_pkg::ADDR_FLAG_POL
      |=> o_reg_rdata[NF-1:0] == $past(flag_pol_q))
    else $error("polarity read returned wrong value");

  a_cause_readonly: assert property (
    i_reg_wr && i_reg_addr == fpia_pkg::ADDR_CAUSE && !any_req
      |=> cause_q == 16'h0000)
    else $error("cause latch took a write");

  a_unmapped_read: assert property (
    i_reg_rd && i_reg_addr != fpia_pkg::ADDR_FLAG_POL
      && i_reg_addr != fpia_pkg::ADDR_CAUSE |=> o_reg_rdata == 16'h0000)
    else $error("unmapped read not zero");

  a_trig_routed: assert property (
    i_flag_src[3] |=> !o_trig_act[0])
    else $error("trigger active while pin used as flag");

  a_out_oe_off: assert property (
    !i_flag_src[11] |=> !o_pin_oe[11] && !o_pin_out[11])
    else $error("unrouted pin driven");

endmodule : fpia_top
`default_nettype wire

// [fpia_host_model.sv]
// Purpose: Behavioural host controller on the register port and request pin
// Assumes: One-cycle strobes, read data one cycle after the read edge
// Notes:   Released data and address lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module fpia_host_model (
  input  wire logic        i_core_clk,  // System clock
  input  wire logic        i_req_n,     // Device request pin, active low
  input  wire logic [15:0] i_rdata,     // Register read data
  output var  logic [9:0]  o_reg_addr,  // Register index
  output var  logic        o_reg_wr,    // Write strobe
  output var  logic        o_reg_rd,    // Read strobe
  output var  logic [15:0] o_reg_wdata  // Write data
);
  initial begin
    {o_reg_addr, o_reg_wr, o_reg_rd, o_reg_wdata} = '0;
  end
  task automatic wr(input logic [9:0] a, input logic [15:0] v);
    @(posedge i_core_clk);
    o_reg_addr  <= a;
    o_reg_wdata <= v;
    o_reg_wr    <= 1'b1;
    @(posedge i_core_clk);
    o_reg_wr    <= 1'b0;
    o_reg_addr  <= ~a;
    o_reg_wdata <= ~v;
  endtask : wr
  task automatic rd(input logic [9:0] a, output logic [15:0] v);
    @(posedge i_core_clk);
    o_reg_addr <= a;
    o_reg_rd   <= 1'b1;
    @(posedge i_core_clk);
    o_reg_rd   <= 1'b0;
    o_reg_addr <= ~a;
    #1;
    v = i_rdata;
  endtask : rd
  // Find the cause of a request
  task automatic service(output logic [15:0] v);
    rd(fpia_pkg::ADDR_CAUSE, v);
  endtask : service
endmodule : fpia_host_model
`default_nettype wire

// [fpia_top_tb.sv]
// Purpose: Self-checking bench for the polarity and request aggregator
// Assumes: Host model owns the register port
// Notes:   Sources and flag inputs change on rising edges
`timescale 1ns/1ps
`default_nettype none
module fpia_top_tb;
  typedef struct packed {logic [12:0] src; logic [15:0] cause;} fpia_row_t;
  logic        clk;
  logic        nrst;
  logic        req_n;
  logic        wr;
  logic        rd;
  logic [9:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [15:0] d;
  logic [12:0] src;
  logic [12:0] fsrc;
  logic [12:0] fdir;
  logic [12:0] fint;
  logic [12:0] fpin;
  logic [12:0] bus;
  logic [12:0] pout;
  logic [12:0] poe;
  logic [5:0]  trig;
  int          fail_count = 0;
  int          n_checks = 0;
  fpia_row_t   rows [8] = '{
    '{13'h000f, 16'h000f},
    '{13'h00f0, 16'h00f0},
    '{13'h0100, 16'h0100},
    '{13'h0200, 16'h0200},
    '{13'h0400, 16'h0400},
    '{13'h0800, 16'h0800},
    '{13'h1000, 16'h1000},
    '{13'h1fff, 16'h1fff}};
  fpia_top DUT (
    .i_core_clk(clk), .i_nrst(nrst), .i_reg_addr(addr),
    .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .i_core_short_halt(src[3:0]), .i_core_soft_request(src[7:4]),
    .i_drv_disabled(src[8]), .i_serial_err(src[9]),
    .i_clk_missing(src[10]), .i_code_check_fail_chan_one(src[11]),
    .i_code_check_fail_chan_two(src[12]), .i_flag_src(fsrc),
    .i_flag_dir(fdir), .i_int_flags(fint), .i_pin_in(fpin),
    .o_flag_bus(bus), .o_pin_out(pout), .o_pin_oe(poe),
    .o_trig_act(trig), .o_host_request_pin_n(req_n));
  fpia_host_model host (
    .i_core_clk(clk), .i_req_n(req_n), .i_rdata(rdata),
    .o_reg_addr(addr), .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_wdata(wdata));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e,
                     input string m);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report
  initial begin
    #2000000;
    fail_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    final_report();
  end
  initial begin
    nrst = 1'b0;
    {src, fsrc, fdir, fint, fpin} = '0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    step(1);
    chk(16'(req_n), 16'h0001, "idle pin");
    host.rd(fpia_pkg::ADDR_FLAG_POL, d);
    chk(d, fpia_pkg::FLAG_POL_RST, "pol reset");
    host.service(d);
    chk(d, fpia_pkg::CAUSE_RST, "cause reset");
    $display("test reset done");
    foreach (rows[i]) begin
      @(posedge clk);
      src <= rows[i].src;
      step(2);
      chk(16'(req_n), 16'h0000, "pin low");
      host.service(d);
      chk(d, rows[i].cause, "captured");
      @(posedge clk);
      src <= 13'h0000;
      step(2);
      chk(16'(req_n), 16'h0001, "pin high");
      host.service(d);
      chk(d, 16'h0000, "cleared");
    end
    $display("test sources done");
    @(posedge clk);
    src <= 13'h0001;
    step(2);
    @(posedge clk);
    src <= 13'h0021;
    host.wr(fpia_pkg::ADDR_CAUSE, 16'hffff);
    host.service(d);
    chk(d, 16'h0001, "held");
    host.rd(10'h3f0, d);
    chk(d, 16'h0000, "unmapped");
    @(posedge clk);
    src <= 13'h0000;
    $display("test hold done");
    host.wr(fpia_pkg::ADDR_FLAG_POL, 16'hffff);
    host.rd(fpia_pkg::ADDR_FLAG_POL, d);
    chk(d, 16'h1fff, "pol rw");
    @(posedge clk);
    fsrc <= 13'h1fff;
    fint <= 13'h0a5a;
    fpin <= 13'h0c33;
    step(2);
    chk(16'(pout), 16'h15a5, "out inv");
    chk(16'(poe), 16'h1fff, "out oe");
    @(posedge clk);
    fdir <= 13'h1fff;
    step(2);
    chk(16'(bus), 16'h13cc, "in inv");
    chk(16'(poe), 16'h0000, "in oe");
    @(posedge clk);
    fsrc <= 13'h0000;
    step(2);
    chk(16'(bus), 16'h0a5c, "unrouted");
    chk(16'(trig), 16'h0039, "trig low");
    host.wr(fpia_pkg::ADDR_FLAG_POL, 16'h0000);
    step(2);
    chk(16'(trig), 16'h0006, "trig high");
    $display("test flags done");
    final_report();
  end
endmodule : fpia_top_tb
`default_nettype wire
